// *** pcl_front.v ***
// Parallel byte configuration load front end with reset sequencing
`include "pcl_map.vh"
module pcl_front #(
  parameter POR_STD_CYCLES  = `PCL_POR_STD_MS * `PCL_CLK_KHZ,
  parameter POR_FAST_CYCLES = `PCL_POR_FAST_MS * `PCL_CLK_KHZ
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Supply monitor and straps
  input  wire        supplies_good,
  input  wire        por_delay_select,
  // Configuration pins
  input  wire        cfg_reset_req_n,
  input  wire        cfg_byte_clock,
  input  wire [7:0]  cfg_data,
  input  wire        cfg_ready_i,
  output reg         cfg_ready_o,
  output reg         cfg_ready_oe,
  input  wire        load_complete_flag_i,
  output reg         load_complete_flag_o,
  output reg         load_complete_flag_oe,
  // Byte stream to the expander
  output reg         out_valid,
  input  wire        out_ready,
  output reg  [7:0]  out_data,
  output reg         out_compressed
);
  localparam ST_POWER = 3'h0;
  localparam ST_DELAY = 3'h1;
  localparam ST_RESET = 3'h2;
  localparam ST_LOAD  = 3'h3;
  localparam ST_DONE  = 3'h4;

  // Two-stage synchronisers for every pin input except load_complete_flag_i
  reg  [12:0] sync1;
  reg  [12:0] sync2;
  reg         clk_prev;
  wire        s_good   = sync2[0];
  wire        s_fast   = sync2[1];
  wire        s_req_n  = sync2[2];
  wire        s_clk    = sync2[3];
  wire [7:0]  s_data   = sync2[11:4];
  wire        s_ready  = sync2[12];
  wire        clk_rise = s_clk & ~clk_prev;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [31:0] por_cnt;
  reg  [4:0]  ctrl;
  reg  [31:0] length;
  reg  [31:0] count;
  reg  [1:0]  phase;
  reg         overflow;

  wire [1:0]  scheme = ctrl[`PCL_CTRL_SCHEME_HI:`PCL_CTRL_SCHEME_LO];
  // Decompression and encryption exist outside JTAG, upgrade only in
  // the parallel and fast active serial schemes
  wire        feat_ok   = (scheme != `PCL_SCHEME_JTAG); // [RQ5]
  wire        remote_ok = (scheme == `PCL_SCHEME_PARALLEL) |
                          (scheme == `PCL_SCHEME_FAST_ACTIVE_SERIAL_SCHEME); // [RQ5]
  wire        eff_dec   = ctrl[`PCL_CTRL_DECOMP] & feat_ok; // [RQ5]
  wire        eff_enc   = ctrl[`PCL_CTRL_ENCRYPT] & feat_ok; // [RQ5]
  wire        eff_rem   = ctrl[`PCL_CTRL_REMOTE] & remote_ok; // [RQ5]
  wire        x4_mode   = eff_dec | eff_enc;
  wire        par_mode  = (scheme == `PCL_SCHEME_PARALLEL);

  // In x4 mode only the first rising edge of each group of four takes a byte
  wire        take = clk_rise & (state == ST_LOAD) & par_mode &
                     (~x4_mode | (phase == 2'h0)); // [RQ1] [RQ11]
  wire [31:0] por_target = s_fast ? POR_FAST_CYCLES
                                  : POR_STD_CYCLES; // [RQ7]

  wire        buf_in_ready;
  wire        buf_out_valid;
  wire [8:0]  buf_out_data;
  wire        drain = ~out_valid | out_ready;

  wire        bus_req  = (avs_read | avs_write) & avs_waitrequest;
  wire        bus_wr   = avs_write & ~avs_waitrequest;
  wire        clr_ovf  = bus_wr & (avs_address == `PCL_REG_STATUS) &
                         avs_writedata[`PCL_ST_OVERFLOW];
  wire [7:0]  status = {eff_rem, eff_enc, eff_dec, x4_mode,
                        (state == ST_POWER) | (state == ST_DELAY),
                        overflow, state == ST_DONE, s_ready};

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1    <= 13'h0000;
      sync2    <= 13'h0000;
      clk_prev <= 1'b0;
    end
    else
    begin
      sync1    <= {cfg_ready_i, cfg_data, cfg_byte_clock, cfg_reset_req_n,
                   por_delay_select, supplies_good};
      sync2    <= sync1;
      clk_prev <= s_clk;
    end
  end

  always @*
  begin
    next_state = state;
    case (state)
      ST_POWER:
        if (s_good)
          next_state = ST_DELAY; // [RQ6]
      ST_DELAY:
        if (por_cnt >= por_target - 32'h1)
          next_state = ST_RESET; // [RQ7]
      ST_RESET:
        if (s_req_n)
          next_state = ST_LOAD; // [RQ12]
      ST_LOAD:
        if (take & (count + 32'h1 >= length - 32'h1))
          next_state = ST_DONE; // [RQ14]
      ST_DONE:
        next_state = ST_DONE;
      default:
        next_state = ST_POWER;
    endcase
    // Brown-out overrides every other step, reset request only during load and done
    if (~s_good)
      next_state = ST_POWER; // [RQ8]
    else if (~s_req_n & (state == ST_LOAD || state == ST_DONE))
      next_state = ST_RESET; // [RQ12]
  end

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state                 <= ST_POWER;
      por_cnt               <= 32'h00000000;
      count                 <= 32'h00000000;
      phase                 <= 2'h0;
      overflow              <= 1'b0;
      cfg_ready_o           <= 1'b0;
      cfg_ready_oe          <= 1'b1;
      load_complete_flag_o  <= 1'b0;
      load_complete_flag_oe <= 1'b1;
    end
    else
    begin
      state   <= next_state;
      por_cnt <= (state == ST_DELAY) ? por_cnt + 32'h1 : 32'h00000000;
      if (state != ST_LOAD)
      begin
        count <= (state == ST_DONE) ? count : 32'h00000000;
        phase <= 2'h0;
      end
      else if (clk_rise)
      begin
        phase <= phase + 2'h1;
        if (take)
          count <= count + 32'h1;
      end
      // The host cannot be stalled, so a byte with no room is recorded
      if (take & ~buf_in_ready)
        overflow <= 1'b1;
      else if (clr_ovf)
        overflow <= 1'b0;
      // Open-drain ready held low through power-up and reset
      cfg_ready_oe <= ~(next_state == ST_LOAD ||
                        next_state == ST_DONE); // [RQ6] [RQ12]
      load_complete_flag_oe <= (next_state != ST_DONE); // [RQ14]
    end
  end

  // Compressed bytes are tagged so the expander unpacks them in flight
  pcl_skid #(
    .W (9)
  ) u_buf (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (take),
    .in_ready  (buf_in_ready),
    .in_data   ({eff_dec, s_data}), // [RQ4]
    .out_valid (buf_out_valid),
    .out_ready (drain),
    .out_data  (buf_out_data)
  );

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_valid      <= 1'b0;
      out_data       <= 8'h00;
      out_compressed <= 1'b0;
    end
    else if (drain)
    begin
      out_valid      <= buf_out_valid;
      out_data       <= buf_out_data[7:0];
      out_compressed <= buf_out_data[8]; // [RQ4]
    end
  end

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      ctrl            <= `PCL_CTRL_RESET;
      length          <= `PCL_LENGTH_RESET;
    end
    else
    begin
      avs_waitrequest <= ~bus_req;
      if (bus_req & avs_read)
      begin
        case (avs_address)
          `PCL_REG_CTRL:   avs_readdata <= {27'h0000000, ctrl};
          `PCL_REG_LENGTH: avs_readdata <= length;
          `PCL_REG_STATUS: avs_readdata <= {24'h000000, status};
          `PCL_REG_COUNT:  avs_readdata <= count;
          default:         avs_readdata <= 32'h00000000;
        endcase
      end
      if (bus_wr & (avs_address == `PCL_REG_CTRL))
        ctrl <= avs_writedata[4:0];
      if (bus_wr & (avs_address == `PCL_REG_LENGTH))
        length <= avs_writedata;
    end
  end
endmodule

// *** pcl_front_chk.sv ***
// Assertion checker for the parallel configuration load front end
module pcl_front_chk (
  // Clock and reset
  input wire       mclk,
  input wire       sys_rst,
  // Supply and host pins
  input wire       supplies_good,
  input wire       cfg_reset_req_n,
  input wire       cfg_ready_o,
  input wire       cfg_ready_oe,
  input wire       load_complete_flag_o,
  input wire       load_complete_flag_oe,
  // Byte stream
  input wire       out_valid,
  input wire       out_ready,
  input wire [7:0] out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_pwr_hold:
    assert property (!supplies_good [*5] |-> cfg_ready_oe)
    else $error("ready released without supplies");
  a_brown_out:
    assert property ($fell(supplies_good) |-> ##[1:6] cfg_ready_oe)
    else $error("no reset after supply drop");
  a_req_hold:
    assert property (!cfg_reset_req_n [*5] |-> cfg_ready_oe)
    else $error("ready released while request low");
  // Sync stages plus the shortest delay must lie between
  a_por_min:
    assert property ($fell(cfg_ready_oe) |-> $past(supplies_good, 7))
    else $error("ready released before reset delay");
  a_done_load:
    assert property ($fell(load_complete_flag_oe) |-> !cfg_ready_oe)
    else $error("complete flag released outside load");
  a_done_rst:
    assert property (cfg_ready_oe && $past(cfg_ready_oe)
      |-> load_complete_flag_oe)
    else $error("complete flag free during reset");
  a_out_hold:
    assert property (out_valid && !out_ready
      |=> out_valid && $stable(out_data))
    else $error("stalled byte lost or changed");
  a_open_drain:
    assert property (!cfg_ready_o && !load_complete_flag_o)
    else $error("open-drain pin driven high");
endmodule

// *** pcl_front_tb.sv ***
// Testbench for the parallel configuration load front end
module pcl_front_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic [3:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic        avs_waitrequest, supplies_good = 1, out_ready = 1;
  logic        por_delay_select = 0, cfg_reset_req_n = 0;
  logic        cfg_ready_o, cfg_ready_oe, out_valid, out_compressed;
  logic        load_complete_flag_o, load_complete_flag_oe;
  logic [7:0]  out_data;
  wire  [7:0]  cfg_data;
  wire         cfg_byte_clock;
  wire         cfg_ready_i = cfg_ready_oe ? cfg_ready_o : 1'h1;
  wire         load_complete_flag_i = load_complete_flag_oe ? 1'h0 : 1'h1;
  logic [8:0]  q[$];
  int          err_total = 0, samples_checked = 0;
  always #5 mclk = ~mclk;
  pcl_front #(.POR_STD_CYCLES(20), .POR_FAST_CYCLES(5)) dut_u (.*);
  pcl_host host_u (.*);
  always @(posedge mclk)
    if (out_valid === 1'h1 && out_ready)
      q.push_back({out_compressed, out_data});
  task print_verdict;
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // Only the watchdog ends a wait for the answer
    do @(posedge mclk); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task wait_free(output int n);
    n = 0;
    while (cfg_ready_oe !== 1'h0 && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
  endtask
  task t_req;
    int n;
    cyc(60);
    chk("ready_held", 1, cfg_ready_oe);
    cfg_reset_req_n <= 1'h1;
    wait_free(n);
    chk("ready_free", 0, cfg_ready_oe);
  endtask
  task t_por(input logic sel, input int lo, hi);
    int n;
    por_delay_select <= sel;
    supplies_good <= 1'h0;
    cyc(6);
    chk("brownout", 1, cfg_ready_oe);
    supplies_good <= 1'h1;
    wait_free(n);
    chk("por_cycles", 1, n >= lo && n <= hi);
  endtask
  task t_cfg;
    for (int s = 0; s < 4; s++)
    begin
      bus(1, 4'h0, 32'h7 | s << 3);
      bus(0, 4'h8, 32'h0);
      chk("features", {s < 2, s < 3, s < 3}, rd[7:5]);
    end
    bus(1, 4'h4, 32'h4);
    bus(0, 4'h4, 32'h0);
    chk("length", 4, rd);
    bus(0, 4'h2, 32'h0);
    chk("unmapped", 0, rd);
    bus(1, 4'h0, 32'h0);
  endtask
  task t_load;
    out_ready <= 1'h0;
    host_u.send(8'hA5, 1);
    host_u.send(8'h3C, 1);
    cyc(8);
    chk("stalled", 0, q.size());
    chk("done_early", 1, load_complete_flag_oe);
    out_ready <= 1'h1;
    host_u.send(8'h5A, 1);
    cyc(8);
    chk("done", 0, load_complete_flag_oe);
    chk("stream", {9'h0A5, 9'h03C, 9'h05A}, {q[0], q[1], q[2]});
    bus(0, 4'hC, 32'h0);
    chk("count", 3, rd);
    bus(0, 4'h8, 32'h0);
    chk("done_ready", 2'h3, rd[1:0]);
  endtask
  task t_x4;
    int n;
    cfg_reset_req_n <= 1'h0;
    cyc(8);
    chk("restart", 1, load_complete_flag_oe);
    bus(1, 4'h0, 32'h1);
    bus(1, 4'h4, 32'h64);
    bus(0, 4'h8, 32'h0);
    chk("x4_mode", 1, rd[4]);
    cfg_reset_req_n <= 1'h1;
    wait_free(n);
    q.delete();
    host_u.send(8'hC3, 4);
    host_u.send(8'h96, 4);
    cyc(8);
    chk("x4_stream", {9'h1C3, 9'h196}, {q[0], q[1]});
    chk("x4_count", 2, q.size());
    // Output register and both buffer slots fill, the fourth byte drops
    out_ready <= 1'h0;
    host_u.send(8'h11, 16);
    bus(0, 4'h8, 32'h0);
    chk("overflow", 1, rd[2]);
    bus(1, 4'h8, 32'h4);
    bus(0, 4'h8, 32'h0);
    chk("overflow_clr", 0, rd[2]);
    out_ready <= 1'h1;
  endtask
  initial
  begin
    cyc(12);
    sys_rst <= 1'h0;
    t_req;
    t_por(0, 21, 28);
    t_por(1, 6, 13);
    t_cfg;
    t_load;
    t_x4;
    print_verdict;
  end
  initial
  begin
    #100000;
    err_total++;
    print_verdict;
  end
endmodule
bind pcl_front pcl_front_chk chk_u (.*);

// *** pcl_host.sv ***
// Configuration host model: byte clock and data lanes
module pcl_host (
  // Configuration pins
  input  wire        cfg_ready_i,
  output logic       cfg_byte_clock,
  output logic [7:0] cfg_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cfg_byte_clock = 1'h0;
    cfg_data = 8'h00;
  end
  // Clock runs only inside a transfer, 125 ns period
  task send(input logic [7:0] b, input int reps);
    wait (cfg_ready_i === 1'h1);
    // Keeps the lanes off the mclk edge and apart from the last release
    #1;
    repeat (reps)
    begin
      cfg_data <= b;
      #31 cfg_byte_clock <= 1'h1;
      #62 cfg_byte_clock <= 1'h0;
      #32;
    end
    // Inverted so a stale byte can never pass for a fresh one
    cfg_data <= ~b;
  endtask
endmodule

// *** pcl_map.vh ***
// Constants for the parallel configuration load front end
// Overview of operation
// (RQ1) Plain mode: one byte per clock edge
// (RQ2) Host clocks four times byte rate when protected
// (RQ3) Host keeps byte clock at most 125 MHz
// (RQ4) Compressed stream accepted and expanded while loading
// (RQ5) Feature availability depends on the load scheme
// (RQ6) Reset holds ready low until supplies good
// (RQ7) Pin selects standard or fast reset delay
// (RQ8) Supply drop forces brown-out reset
// (RQ9) Host holds reset request low on slow ramps
// (RQ10) Host fetches bytes from storage and presents them
// (RQ11) Latch on rising edge, first of four
// (RQ12) Host starts load by raising reset request
// (RQ13) Host sends bytes once ready reads high
// (RQ14) Complete flag released after next-to-last byte
`ifndef PCL_MAP_VH
`define PCL_MAP_VH
`define PCL_CLK_KHZ        100000
`define PCL_POR_STD_MS     100
`define PCL_POR_FAST_MS    4
`define PCL_BYTE_CLK_MHZ   125
`define PCL_REG_CTRL       4'h0
`define PCL_REG_LENGTH     4'h4
`define PCL_REG_STATUS     4'h8
`define PCL_REG_COUNT      4'hC
`define PCL_CTRL_DECOMP    0
`define PCL_CTRL_ENCRYPT   1
`define PCL_CTRL_REMOTE    2
`define PCL_CTRL_SCHEME_LO 3
`define PCL_CTRL_SCHEME_HI 4
`define PCL_CTRL_RESET     5'h00
`define PCL_LENGTH_RESET   32'h00000000
`define PCL_ST_READY       0
`define PCL_ST_DONE        1
`define PCL_ST_OVERFLOW    2
`define PCL_ST_POR_BUSY    3
`define PCL_ST_X4          4
`define PCL_ST_DECOMP      5
`define PCL_ST_ENCRYPT     6
`define PCL_ST_REMOTE      7
`define PCL_SCHEME_PARALLEL 2'h0
`define PCL_SCHEME_FAST_ACTIVE_SERIAL_SCHEME  2'h1
`define PCL_SCHEME_PASSIVE  2'h2
`define PCL_SCHEME_JTAG     2'h3
`endif

// *** pcl_skid.v ***
// Two-entry buffer with valid and ready on both sides
module pcl_skid #(
  parameter W = 9
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         sys_rst,
  // Fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] slot [0:1];
  reg         rd_ptr;
  reg         wr_ptr;
  reg [1:0]   fill;
  wire        push;
  wire        pop;

  assign in_ready  = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_data  = slot[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fill   <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push & ~pop)
        fill <= fill + 2'h1;
      else if (pop & ~push)
        fill <= fill - 2'h1;
    end
  end

  always @(posedge mclk)
  begin
    if (push)
      slot[wr_ptr] <= in_data;
  end
endmodule
